// >>> core/pitc_idle_timer.sv
// One restartable timeout counter driven by a slow tick.
`timescale 1ns/1ps
`default_nettype none
module pitc_idle_timer (
    input  wire logic clk_sys,
    input  wire logic rstn,
    pitc_tick_if.timer port
);
    pitc_pkg::pitc_limit_t count_q;
    logic                  expired_q;
    logic                  lastTick;

    assign lastTick = port.tick && (count_q >= port.limit - 16'h0001);
    assign port.expired = expired_q;

    // Activity wins over an expiry in the same cycle, since the resource was not idle.
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            count_q   <= 16'h0000;
            expired_q <= 1'b0;
        end else if (port.restart || !port.enable) begin
            count_q   <= 16'h0000;
            expired_q <= 1'b0;
        end else if (port.tick && !expired_q) begin
            count_q   <= lastTick ? 16'h0000 : count_q + 16'h0001;
            expired_q <= lastTick;
        end
    end

    chk_restart_clears: assert property (
        @(posedge clk_sys) disable iff (!rstn)
        port.restart |=> (count_q == 16'h0000) && !expired_q)
        else $error("Counter not cleared after activity.");

    chk_expiry_cause: assert property (
        @(posedge clk_sys) disable iff (!rstn)
        $rose(expired_q) |-> $past(port.tick) && !$past(port.restart) && $past(port.enable)
            && ($past(count_q) == $past(port.limit) - 16'h0001))
        else $error("Timeout raised without a full idle count.");
endmodule : pitc_idle_timer
`default_nettype wire

// >>> core/pitc_top.sv
// Idle and doze timeout configuration registers with their five timeout counters.
//
// Chosen here: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "pitc_regs.svh"
module pitc_top #(
    parameter int MS_CYCLES     = `PITC_MS_NS / `PITC_CLK_PERIOD_NS,
    parameter int SUBSEC_CYCLES = `PITC_SUBSEC_NS / `PITC_CLK_PERIOD_NS
) (
    input  wire logic        clk_sys,
    input  wire logic        rstn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output var  logic [31:0] prdata,
    output var  logic        pready,
    output var  logic        pslverr,
    input  wire logic        intAck,
    input  wire logic        sysEventActivity,
    input  wire logic        vramActivity,
    input  wire logic        csDevActivity,
    input  wire logic        hddActivity,
    output var  logic        turboHold,
    output var  logic        sysDozeReq,
    output var  logic        vramDozeReq,
    output var  logic        csDevStandbyReq,
    output var  logic        hddStandbyReq
);
    // ------------------------------------------------------------------------
    // Register bus
    // ------------------------------------------------------------------------
    logic [7:0]  dozeCfg_q;
    logic [7:0]  standbyCfg_q;
    logic        turboSeen_q;
    logic        access;
    logic        complete;
    logic        hitDoze;
    logic        hitStandby;
    logic        hitStatus;
    logic        hitAny;
    logic        wrDoze;
    logic        wrStandby;
    logic [31:0] rdMux;
    logic [7:0]  statusW;

    // One wait state keeps prdata and pready straight from flip-flops.
    assign access     = psel && penable && !pready;
    // Writes land at the completing edge, where the master samples pready high.
    assign complete   = psel && penable && pready;
    assign hitDoze    = (paddr == 12'(`PITC_ADDR_DOZE));
    assign hitStandby = (paddr == 12'(`PITC_ADDR_STANDBY));
    assign hitStatus  = (paddr == 12'(`PITC_ADDR_STATUS));
    assign hitAny     = hitDoze || hitStandby || hitStatus;
    assign wrDoze     = complete && pwrite && hitDoze;
    assign wrStandby  = complete && pwrite && hitStandby;
    assign statusW    = {3'h0, hddStandbyReq, csDevStandbyReq, vramDozeReq,
                         sysDozeReq, turboHold};
    assign rdMux      = hitDoze    ? {24'h000000, dozeCfg_q}    :
                        hitStandby ? {24'h000000, standbyCfg_q} :
                        hitStatus  ? {24'h000000, statusW}      : 32'h00000000;

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h00000000;
        end else begin
            pready  <= access;
            pslverr <= access && !(hitAny && !(pwrite && hitStatus));
            prdata  <= (access && !pwrite) ? rdMux : 32'h00000000;
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            dozeCfg_q    <= `PITC_RESET_DOZE;
            standbyCfg_q <= `PITC_RESET_STANDBY;
        end else begin
            if (wrDoze) begin
                dozeCfg_q <= pwdata[7:0];
            end
            if (wrStandby) begin
                standbyCfg_q <= pwdata[7:0];
            end
        end
    end

    // ------------------------------------------------------------------------
    // Time base
    // ------------------------------------------------------------------------
    logic [19:0] msDiv_q;
    logic [19:0] subDiv_q;
    logic        msTick_q;
    logic        subTick_q;

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            msDiv_q   <= 20'h00000;
            subDiv_q  <= 20'h00000;
            msTick_q  <= 1'b0;
            subTick_q <= 1'b0;
        end else begin
            msTick_q  <= (msDiv_q == 20'(MS_CYCLES - 1));
            subTick_q <= (subDiv_q == 20'(SUBSEC_CYCLES - 1));
            msDiv_q   <= (msDiv_q == 20'(MS_CYCLES - 1)) ? 20'h00000 : msDiv_q + 20'h00001;
            subDiv_q  <= (subDiv_q == 20'(SUBSEC_CYCLES - 1)) ? 20'h00000
                                                               : subDiv_q + 20'h00001;
        end
    end

    // ------------------------------------------------------------------------
    // Timeout selection
    // ------------------------------------------------------------------------
    logic [1:0] turboCode;
    logic [2:0] sysCode;
    logic [2:0] vramCode;
    logic [3:0] csDevCode;
    logic [3:0] hddCode;
    pitc_pkg::pitc_limit_t limitW [pitc_pkg::PITC_NUM];
    logic       tickW    [pitc_pkg::PITC_NUM];
    logic       restartW [pitc_pkg::PITC_NUM];
    logic       enableW  [pitc_pkg::PITC_NUM];
    logic       expiredW [pitc_pkg::PITC_NUM];

    assign turboCode = dozeCfg_q[`PITC_TURBO_HI:`PITC_TURBO_LO];
    assign sysCode   = dozeCfg_q[`PITC_SYSDOZE_HI:`PITC_SYSDOZE_LO];
    assign vramCode  = dozeCfg_q[`PITC_VRAM_HI:`PITC_VRAM_LO];
    assign csDevCode = standbyCfg_q[`PITC_CSDEV_HI:`PITC_CSDEV_LO];
    assign hddCode   = standbyCfg_q[`PITC_HDD_HI:`PITC_HDD_LO];

    assign limitW[pitc_pkg::PITC_TURBO]   = 16'h0001 << {turboCode, 1'b0};
    assign limitW[pitc_pkg::PITC_SYSDOZE] = 16'h0001 << (sysCode - 3'h1);
    assign limitW[pitc_pkg::PITC_VRAM]    = 16'h0001 << (vramCode - 3'h1);
    assign limitW[pitc_pkg::PITC_CSDEV]   = {12'h000, csDevCode} * 16'(`PITC_MIN_SUBTICKS);
    assign limitW[pitc_pkg::PITC_HDD]     = {12'h000, hddCode} * 16'(`PITC_MIN_SUBTICKS);

    assign tickW[pitc_pkg::PITC_TURBO]   = msTick_q;
    assign tickW[pitc_pkg::PITC_SYSDOZE] = subTick_q;
    assign tickW[pitc_pkg::PITC_VRAM]    = msTick_q;
    assign tickW[pitc_pkg::PITC_CSDEV]   = subTick_q;
    assign tickW[pitc_pkg::PITC_HDD]     = subTick_q;

    // A new timeout setting restarts its counter so no stale count is compared to it.
    assign restartW[pitc_pkg::PITC_TURBO]   = intAck || wrDoze;
    assign restartW[pitc_pkg::PITC_SYSDOZE] = sysEventActivity || wrDoze;
    assign restartW[pitc_pkg::PITC_VRAM]    = vramActivity || wrDoze;
    assign restartW[pitc_pkg::PITC_CSDEV]   = csDevActivity || wrStandby;
    assign restartW[pitc_pkg::PITC_HDD]     = hddActivity || wrStandby;

    assign enableW[pitc_pkg::PITC_TURBO]   = 1'b1;
    assign enableW[pitc_pkg::PITC_SYSDOZE] = (sysCode != 3'h0);
    assign enableW[pitc_pkg::PITC_VRAM]    = (vramCode != 3'h0);
    assign enableW[pitc_pkg::PITC_CSDEV]   = (csDevCode != 4'h0);
    assign enableW[pitc_pkg::PITC_HDD]     = (hddCode != 4'h0);

    // ------------------------------------------------------------------------
    // Timeout counters
    // ------------------------------------------------------------------------
    pitc_tick_if tIf [pitc_pkg::PITC_NUM] ();

    for (genvar i = 0; i < pitc_pkg::PITC_NUM; i++) begin : gTimer
        assign tIf[i].tick    = tickW[i];
        assign tIf[i].restart = restartW[i];
        assign tIf[i].enable  = enableW[i];
        assign tIf[i].limit   = limitW[i];
        assign expiredW[i]    = tIf[i].expired;
        pitc_idle_timer uTimer (
            .clk_sys (clk_sys),
            .rstn    (rstn),
            .port    (tIf[i].timer)
        );
    end

    // ------------------------------------------------------------------------
    // Power-state outputs
    // ------------------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            turboSeen_q     <= 1'b0;
            turboHold       <= 1'b0;
            sysDozeReq      <= 1'b0;
            vramDozeReq     <= 1'b0;
            csDevStandbyReq <= 1'b0;
            hddStandbyReq   <= 1'b0;
        end else begin
            turboSeen_q     <= turboSeen_q || intAck;
            // A fresh acknowledge wins over an expiry flag that is only now being cleared.
            turboHold       <= (turboSeen_q || intAck)
                               && (intAck || !expiredW[pitc_pkg::PITC_TURBO]);
            sysDozeReq      <= expiredW[pitc_pkg::PITC_SYSDOZE];
            vramDozeReq     <= expiredW[pitc_pkg::PITC_VRAM];
            csDevStandbyReq <= expiredW[pitc_pkg::PITC_CSDEV];
            hddStandbyReq   <= expiredW[pitc_pkg::PITC_HDD];
        end
    end

    // ------------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------------
    chk_turbo_period_map: assert property (
        @(posedge clk_sys) disable iff (!rstn)
        (turboCode == 2'h0 |-> limitW[pitc_pkg::PITC_TURBO] == 16'h0001)
        and (turboCode == 2'h3 |-> limitW[pitc_pkg::PITC_TURBO] == 16'h0040))
        else $error("Turbo hold period does not match its code.");

    chk_turbo_after_ack: assert property (
        @(posedge clk_sys) disable iff (!rstn)
        intAck ##1 !intAck |-> turboHold)
        else $error("Turbo not held after interrupt acknowledge.");

    chk_sysdoze_off: assert property (
        @(posedge clk_sys) disable iff (!rstn)
        (sysCode == 3'h0)[*3] |-> !sysDozeReq)
        else $error("System doze raised while disabled.");

    chk_sysdoze_longest: assert property (
        @(posedge clk_sys) disable iff (!rstn)
        sysCode == 3'h7 |-> limitW[pitc_pkg::PITC_SYSDOZE] == 16'h0040)
        else $error("Two second system doze limit wrong.");

    chk_vram_map: assert property (
        @(posedge clk_sys) disable iff (!rstn)
        (vramCode == 3'h1 |-> limitW[pitc_pkg::PITC_VRAM] == 16'h0001)
        and (vramCode == 3'h7 |-> limitW[pitc_pkg::PITC_VRAM] == 16'h0040))
        else $error("Video memory doze limit wrong.");

    chk_csdev_minutes: assert property (
        @(posedge clk_sys) disable iff (!rstn)
        csDevCode == 4'hf |-> limitW[pitc_pkg::PITC_CSDEV] == 16'h7080)
        else $error("Chip-select standby limit wrong.");

    chk_hdd_minutes: assert property (
        @(posedge clk_sys) disable iff (!rstn)
        hddCode == 4'h1 |-> limitW[pitc_pkg::PITC_HDD] == 16'h0780)
        else $error("Hard disk standby limit wrong.");

    chk_hdd_activity_drop: assert property (
        @(posedge clk_sys) disable iff (!rstn)
        hddActivity |-> ##2 !hddStandbyReq)
        else $error("Hard disk standby held through activity.");
endmodule : pitc_top
`default_nettype wire

// >>> include/pitc_pkg.sv
// Types shared by the idle timeout block.
`default_nettype none
package pitc_pkg;
    typedef logic [15:0] pitc_limit_t;
    typedef enum int {
        PITC_TURBO   = 0,
        PITC_SYSDOZE = 1,
        PITC_VRAM    = 2,
        PITC_CSDEV   = 3,
        PITC_HDD     = 4,
        PITC_NUM     = 5
    } pitc_timer_t;
endpackage : pitc_pkg
`default_nettype wire

// >>> include/pitc_regs.svh
// Register map, field positions, reset values and time constants of the idle timeout block.
`ifndef PITC_REGS_SVH
`define PITC_REGS_SVH

// ----------------------------------------------------------------------------
// Register indices and byte addresses
// ----------------------------------------------------------------------------
`define PITC_IDX_DOZE          12'h054
`define PITC_IDX_STANDBY       12'h055
`define PITC_IDX_STATUS        12'h058
`define PITC_ADDR_DOZE         (`PITC_IDX_DOZE << 2)
`define PITC_ADDR_STANDBY      (`PITC_IDX_STANDBY << 2)
`define PITC_ADDR_STATUS       (`PITC_IDX_STATUS << 2)
`define PITC_RESET_DOZE        8'h00
`define PITC_RESET_STANDBY     8'h00

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define PITC_TURBO_HI          7
`define PITC_TURBO_LO          6
`define PITC_SYSDOZE_HI        5
`define PITC_SYSDOZE_LO        3
`define PITC_VRAM_HI           2
`define PITC_VRAM_LO           0
`define PITC_CSDEV_HI          7
`define PITC_CSDEV_LO          4
`define PITC_HDD_HI            3
`define PITC_HDD_LO            0

// ----------------------------------------------------------------------------
// Time base
// ----------------------------------------------------------------------------
`define PITC_CLK_PERIOD_NS     100
`define PITC_MS_NS             1000000
`define PITC_SUBSEC_NS         31250000
`define PITC_SUBSEC_PER_SEC    32
`define PITC_SEC_PER_MIN       60
`define PITC_MIN_SUBTICKS      (`PITC_SEC_PER_MIN * `PITC_SUBSEC_PER_SEC)

`endif

// >>> include/pitc_tick_if.sv
// Control and result signals between the top and one timeout counter.
`timescale 1ns/1ps
`default_nettype none
interface pitc_tick_if;
    logic                 tick;
    logic                 restart;
    logic                 enable;
    pitc_pkg::pitc_limit_t limit;
    logic                 expired;
    modport timer (input tick, input restart, input enable, input limit, output expired);
    modport ctrl  (output tick, output restart, output enable, output limit, input expired);
endinterface : pitc_tick_if
`default_nettype wire

// >>> verification/pitc_tb_top.sv
// Self-checking testbench for the idle and doze timeout configuration block.
`timescale 1ns/1ps
`default_nettype none
`include "pitc_regs.svh"
module pitc_tb_top;
    // Short time base keeps the minute timers inside the run budget.
    localparam int MS  = 4;
    localparam int SUB = 8;
    localparam int MIN = `PITC_MIN_SUBTICKS;

    logic        clk_sys  = 1'b0;
    logic        rstn     = 1'b0;
    logic        psel     = 1'b0;
    logic        penable  = 1'b0;
    logic        pwrite   = 1'b0;
    logic [11:0] paddr    = 12'h000;
    logic [31:0] pwdata   = 32'h0000_0000;
    logic [4:0]  act      = 5'h00;
    wire  [31:0] prdata;
    wire         pready;
    wire         pslverr;
    wire  [4:0]  req;
    int          errCount = 0;
    int          checks   = 0;

    always #50 clk_sys = ~clk_sys;

    // Index order of act and req follows the timer enumeration of the package.
    pitc_top #(.MS_CYCLES(MS), .SUBSEC_CYCLES(SUB)) i_dut (
        .clk_sys(clk_sys), .rstn(rstn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .intAck(act[0]),
        .sysEventActivity(act[1]), .vramActivity(act[2]), .csDevActivity(act[3]),
        .hddActivity(act[4]), .turboHold(req[0]), .sysDozeReq(req[1]),
        .vramDozeReq(req[2]), .csDevStandbyReq(req[3]), .hddStandbyReq(req[4])
    );

    // ------------------------------------------------------------------------
    // Reporting
    // ------------------------------------------------------------------------
    task automatic tally_and_finish;
        if (errCount == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : tally_and_finish

    task automatic chk(input logic [31:0] s, input logic [31:0] e, input string m);
        checks++;
        if (s !== e) begin
            errCount++;
            $display("MISMATCH %0t %s seen %h expected %h", $time, m, s, e);
        end
    endtask : chk

    task automatic stop_on_hang(input string m);
        errCount++;
        $display("MISMATCH %0t wait ran out: %s", $time, m);
        tally_and_finish();
    endtask : stop_on_hang

    // ------------------------------------------------------------------------
    // Bus and stimulus helpers
    // ------------------------------------------------------------------------
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        int n;
        @(posedge clk_sys);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge clk_sys);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) stop_on_hang("apb answer");
    endtask : apb

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] rd;
        logic        e;
        apb(1'b1, a, d, rd, e);
        chk({31'h0, e}, 32'h0, "write error flag");
    endtask : wr

    task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] rd;
        logic        e;
        apb(1'b0, a, 32'h0, rd, e);
        chk(rd, exp, "register read");
        chk({31'h0, e}, 32'h0, "read error flag");
    endtask : rdchk

    task automatic pulse(input int k);
        @(posedge clk_sys);
        act[k] <= 1'b1;
        @(posedge clk_sys);
        act[k] <= 1'b0;
    endtask : pulse

    // Counts from the activity edge to the request; a tick may start partial.
    task automatic measure(input int k, input int t, input int n);
        int          c;
        logic [31:0] rd;
        logic        e;
        pulse(k);
        c = 0;
        while (req[k] !== 1'b1 && c < n * t + 20) begin
            @(posedge clk_sys);
            c++;
        end
        if (req[k] !== 1'b1) stop_on_hang("timeout event");
        chk(32'(c >= (n - 1) * t && c <= n * t + 5), 32'h1, "timeout length");
        apb(1'b0, `PITC_ADDR_STATUS, 32'h0, rd, e);
        chk({31'h0, rd[k]}, 32'h1, "status bit");
        if (n * t > 16) begin
            pulse(k);
            repeat (2) @(posedge clk_sys);
            chk({31'h0, req[k]}, 32'h0, "activity clears request");
        end
    endtask : measure

    // ------------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------------
    task automatic reg_scenario;
        logic [31:0] rd;
        logic        e;
        rdchk(`PITC_ADDR_DOZE, 32'h0);
        rdchk(`PITC_ADDR_STANDBY, 32'h0);
        wr(`PITC_ADDR_DOZE, 32'hffff_ffa5);
        rdchk(`PITC_ADDR_DOZE, 32'h0000_00a5);
        wr(`PITC_ADDR_STANDBY, 32'hffff_ff5a);
        rdchk(`PITC_ADDR_STANDBY, 32'h0000_005a);
        apb(1'b0, 12'h15c, 32'h0, rd, e);
        chk({rd[30:0], e}, 32'h1, "unmapped read");
        apb(1'b1, `PITC_ADDR_STATUS, 32'h1f, rd, e);
        chk({31'h0, e}, 32'h1, "status write");
        wr(`PITC_ADDR_DOZE, 32'h0);
        wr(`PITC_ADDR_STANDBY, 32'h0);
    endtask : reg_scenario

    task automatic disabled_scenario;
        int bad;
        bad = 0;
        @(posedge clk_sys);
        act <= 5'h1e;
        @(posedge clk_sys);
        act <= 5'h00;
        repeat (600) begin
            @(posedge clk_sys);
            if (req[4:1] !== 4'h0) bad++;
        end
        chk(32'(bad), 32'h0, "disabled timer fired");
    endtask : disabled_scenario

    task automatic turbo_case(input int code);
        int c;
        int n;
        n = 1 << (2 * code);
        wr(`PITC_ADDR_DOZE, 32'(code << 6));
        pulse(0);
        c = 0;
        while (req[0] !== 1'b1 && c < 4) begin
            @(posedge clk_sys);
            c++;
        end
        chk({31'h0, req[0]}, 32'h1, "turbo raised");
        c = 0;
        while (req[0] === 1'b1 && c < n * MS + 20) begin
            @(posedge clk_sys);
            c++;
        end
        chk(32'(c >= (n - 1) * MS && c <= n * MS + 5), 32'h1, "turbo length");
    endtask : turbo_case

    // Activity kept up inside the window must hold the request off.
    task automatic restart_scenario;
        wr(`PITC_ADDR_DOZE, 32'h4);
        pulse(2);
        repeat (4) begin
            repeat (24) @(posedge clk_sys);
            chk({31'h0, req[2]}, 32'h0, "early event");
            pulse(2);
        end
        measure(2, MS, 8);
    endtask : restart_scenario

    task automatic minutes_case;
        int c;
        int tc;
        int th;
        wr(`PITC_ADDR_STANDBY, 32'h12);
        @(posedge clk_sys);
        act[4:3] <= 2'b11;
        @(posedge clk_sys);
        act[4:3] <= 2'b00;
        c = 0;
        tc = 0;
        th = 0;
        while (!(req[3] === 1'b1 && req[4] === 1'b1) && c < 2 * MIN * SUB + 40) begin
            @(posedge clk_sys);
            c++;
            if (req[3] === 1'b1 && tc == 0) tc = c;
            if (req[4] === 1'b1 && th == 0) th = c;
        end
        chk(32'(tc >= (MIN - 1) * SUB && tc <= MIN * SUB + 5), 32'h1, "one minute");
        chk(32'(th >= (2 * MIN - 1) * SUB && th <= 2 * MIN * SUB + 5), 32'h1, "two min");
        pulse(4);
        repeat (2) @(posedge clk_sys);
        chk({31'h0, req[4]}, 32'h0, "activity clears standby");
    endtask : minutes_case

    task automatic doze_scenario;
        for (int c = 1; c < 8; c++) begin
            wr(`PITC_ADDR_DOZE, 32'(c << 3));
            measure(1, SUB, 1 << (c - 1));
        end
        for (int c = 1; c < 8; c++) begin
            wr(`PITC_ADDR_DOZE, 32'(c));
            measure(2, MS, 1 << (c - 1));
        end
    endtask : doze_scenario

    initial begin
        repeat (20) @(posedge clk_sys);
        rstn <= 1'b1;
        reg_scenario();
        disabled_scenario();
        for (int code = 0; code < 4; code++) begin
            turbo_case(code);
        end
        doze_scenario();
        restart_scenario();
        minutes_case();
        tally_and_finish();
    end
endmodule : pitc_tb_top
`default_nettype wire
